// File: dv/hs_uart_monitor.sv
// Purpose: Port checks for the UART flow/FIFO control block
// Assumes: Full-word writes to the control word
// Notes: Keeps a shadow of the control word
`include "hs_uart_map.vh"

module hs_uart_monitor (
	input logic        aclk,
	input logic        aresetn,
	input logic [7:0]  s_axi_awaddr,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [31:0] s_axi_wdata,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        txd,
	input logic        terminal_ready_pin_n,
	input logic        send_request_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ctl;
	logic        rd_ctl;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Shadow control word and read target
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctl    <= 32'h0;
			rd_ctl <= 1'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFF_CONTROL)
				ctl <= s_axi_wdata & `CONTROL_WMASK;
			if (s_axi_arvalid && s_axi_arready)
				rd_ctl <= (s_axi_araddr == `OFF_CONTROL);
		end
	end
	// Handshake steps
	sequence s_wr_take; s_axi_awready && s_axi_wready; endsequence
	sequence s_rd_take; s_axi_arready; endsequence
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
		|=> s_wr_take ##1 s_axi_bvalid) else $error("write answer late");
	AST_RD_ANSWER: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
		|=> s_rd_take ##1 s_axi_rvalid) else $error("read answer late");
	AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	AST_CTL_READBACK: assert property (s_axi_rvalid && rd_ctl |-> s_axi_rdata == ctl)
		else $error("control readback differs");
	AST_DTR_PIN: assert property (terminal_ready_pin_n == !$past(ctl[24]))
		else $error("terminal ready pin wrong");
	AST_RTS_SW: assert property (!$past(ctl[28]) && !$past(ctl[31])
		|-> send_request_pin_n == !$past(ctl[25])) else $error("request pin wrong");
	AST_START_BIT: assert property ($fell(txd) |-> !txd [*8] ##1 !txd [*8])
		else $error("bit cell short");
endmodule // hs_uart_monitor

// File: dv/tb_hs_uart_flow_fifo_control.sv
// Purpose: Self-checking bench for the UART flow/FIFO block
// Assumes: Bit period 16 clocks, full-word strobes
// Notes: Row table for pins and readback, then hand cases
`include "hs_uart_map.vh"

module tb_hs_uart_flow_fifo_control;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [31:0] w; logic dtr_n; logic rts_n;} row_t;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  last_resp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, rxd;
	wire         clear_to_send_pin_n, terminal_ready_pin_n, send_request_pin_n;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	int          err_count, checks_done;
	logic [5:0]  rx_thr[4] = '{6'h01, 6'h08, 6'h12, 6'h1c};
	logic [5:0]  tx_thr[4] = '{6'h1e, 6'h18, 6'h10, 6'h08};
	row_t        rows[6] = '{{32'h01000000, 1'h0, 1'h1}, {32'h02000000, 1'h1, 1'h0},
		{32'h10000000, 1'h1, 1'h0}, {32'h80000000, 1'h1, 1'h0}, {32'h00fc0000, 1'h1, 1'h1},
		{32'h00000000, 1'h1, 1'h1}};

	hs_uart_flow_fifo_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rxd, .clear_to_send_pin_n, .txd, .terminal_ready_pin_n,
		.send_request_pin_n);
	uart_far_end #(.BIT_CYCLES(16)) i_far (.aclk, .txd, .rxd, .clear_to_send_pin_n);

	// 250 MHz clock
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_left, w_left;
		aw_left = 1'h1;
		w_left  = 1'h1;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		// Each channel is released at its own handshake edge
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				aw_left = 1'h0;
			if (s_axi_wready)
				w_left = 1'h0;
			s_axi_awvalid <= aw_left;
			s_axi_wvalid  <= w_left;
		end while (aw_left || w_left);
		do @(posedge aclk); while (!s_axi_bvalid);
		last_resp = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		last_resp = s_axi_rresp;
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard
	initial begin
		#120000;
		err_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb, s_axi_wdata} = {2'h3, 4'hf, 32'h0};
		{err_count, checks_done} = '0;
		cyc(4);
		aresetn <= 1'h1;
		rd(`OFF_CONTROL, v);
		chk("control reset", 32'h0, v);
		rd(`OFF_CTL_CHAR, v);
		chk("ctl char reset", 32'h1113, v);
		rd(8'h40, v);
		chk("unmapped resp", 32'h2, {30'h0, last_resp});
		chk("unmapped data", 32'h0, v);
		wr(8'h44, 32'h0);
		chk("unmapped wr resp", 32'h2, {30'h0, last_resp});
		foreach (rows[i]) begin
			wr(`OFF_CONTROL, rows[i].w);
			chk("control wr resp", 32'h0, {30'h0, last_resp});
			cyc(2);
			chk("dtr pin", {31'h0, rows[i].dtr_n}, {31'h0, terminal_ready_pin_n});
			chk("flow pin", {31'h0, rows[i].rts_n}, {31'h0, send_request_pin_n});
			rd(`OFF_CONTROL, v);
			chk("control readback", rows[i].w, v);
		end
		// Single receive buffer drives the flow pin
		wr(`OFF_CONTROL, 32'h80000000);
		i_far.send(8'h3c);
		cyc(8);
		chk("rtr single full", 32'h1, {31'h0, send_request_pin_n});
		rd(`OFF_RX_DATA, v);
		chk("rx single data", 32'h3c, v & 32'hff);
		cyc(2);
		chk("rtr single empty", 32'h0, {31'h0, send_request_pin_n});
		// Fill the receive FIFO, thresholds at eight
		wr(`OFF_CONTROL, 32'h80020000);
		for (int n = 1; n <= 32; n++) begin
			i_far.send(n[7:0]);
			cyc(8);
			if (n == 31)
				chk("rtr fifo room", 32'h0, {31'h0, send_request_pin_n});
			for (int c = 0; c < 4 && n == 8; c++) begin
				wr(`OFF_CONTROL, {8'h80, c[1:0], 22'h020000});
				rd(`OFF_STATUS, v);
				chk("rx trigger", {31'h0, 6'h08 >= rx_thr[c]}, {31'h0, v[18]});
			end
		end
		chk("rtr fifo full", 32'h1, {31'h0, send_request_pin_n});
		rd(`OFF_STATUS, v);
		chk("rx count", 32'h20, {26'h0, v[13:8]});
		wr(`OFF_CONTROL, 32'h800a0000);
		cyc(4);
		rd(`OFF_STATUS, v);
		chk("rx cleared", 32'h0, {26'h0, v[13:8]});
		chk("rtr cleared", 32'h0, {31'h0, send_request_pin_n});
		rd(`OFF_CONTROL, v);
		chk("clear kept", 32'h800a0000, v);
		// Software flow pause with a loaded transmit FIFO
		wr(`OFF_CTL_CHAR, 32'h1113);
		wr(`OFF_CONTROL, 32'h20010000);
		i_far.send(8'h13);
		cyc(8);
		rd(`OFF_RX_DATA, v);
		for (int i = 0; i < 10; i++)
			wr(`OFF_TX_DATA, 32'h40 + i);
		cyc(200);
		chk("paused tx", 32'h0, i_far.got.size());
		for (int c = 0; c < 4; c++) begin
			wr(`OFF_CONTROL, {8'h20, 2'h0, c[1:0], 20'h10000});
			rd(`OFF_STATUS, v);
			chk("tx trigger", {31'h0, 6'h16 >= tx_thr[c]}, {31'h0, v[17]});
		end
		i_far.send(8'h11);
		cyc(1800);
		chk("tx count", 32'ha, i_far.got.size());
		foreach (i_far.got[i])
			chk("tx byte", 32'h40 + i, {24'h0, i_far.got[i]});
		rd(`OFF_RX_DATA, v);
		chk("resume stored", 32'h11, v & 32'hff);
		// Echo replaces written data
		i_far.got.delete();
		wr(`OFF_CONTROL, 32'h40000000);
		wr(`OFF_TX_DATA, 32'h5a);
		i_far.send(8'ha5);
		cyc(200);
		chk("echo count", 32'h1, i_far.got.size());
		chk("echo byte", 32'ha5, {24'h0, i_far.got[0]});
		rd(`OFF_RX_DATA, v);
		chk("echo stored", 32'ha5, v & 32'hff);
		// Hardware flow: a raised clear-to-send line stalls new characters
		i_far.got.delete();
		i_far.hold_cts(1'h1);
		wr(`OFF_CONTROL, 32'h10010000);
		wr(`OFF_TX_DATA, 32'h61);
		wr(`OFF_TX_DATA, 32'h62);
		cyc(200);
		chk("cts stall", 32'h0, i_far.got.size());
		chk("flow pin hw", 32'h0, {31'h0, send_request_pin_n});
		i_far.hold_cts(1'h0);
		cyc(400);
		chk("cts resume", 32'h2, i_far.got.size());
		chk("cts byte", 32'h62, {24'h0, i_far.got[1]});
		// Mid-run reset returns pins, control and characters to reset values
		wr(`OFF_CONTROL, 32'h03000000);
		wr(`OFF_CTL_CHAR, 32'h2a2b);
		aresetn <= 1'h0;
		cyc(2);
		aresetn <= 1'h1;
		chk("dtr after reset", 32'h1, {31'h0, terminal_ready_pin_n});
		chk("flow after reset", 32'h1, {31'h0, send_request_pin_n});
		rd(`OFF_CONTROL, v);
		chk("control after reset", 32'h0, v);
		rd(`OFF_CTL_CHAR, v);
		chk("ctl char after reset", 32'h1113, v);
		report_and_stop();
	end
endmodule // tb_hs_uart_flow_fifo_control

bind hs_uart_flow_fifo_control hs_uart_monitor i_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd, .terminal_ready_pin_n,
	.send_request_pin_n);

// File: dv/uart_far_end.sv
// Purpose: Remote terminal on the serial link
// Assumes: 8N1, BIT_CYCLES clocks per bit, idle-high line
// Notes: send() drives frames; frames seen land in got
module uart_far_end #(
	parameter int BIT_CYCLES = 16
) (
	input  logic aclk,
	input  logic txd,
	output logic rxd,
	output logic clear_to_send_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic [7:0] c;
	// Idle line, ready until the bench holds it off
	initial begin
		rxd = 1'h1;
		clear_to_send_pin_n = 1'h0;
	end
	// Raise or drop the clear-to-send line
	task automatic hold_cts(input logic stop);
		clear_to_send_pin_n <= stop;
	endtask
	// One frame, LSB first
	task automatic send(input logic [7:0] ch);
		logic [9:0] f;
		f = {1'h1, ch, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CYCLES) @(posedge aclk);
		end
	endtask
	// Sample frames mid-cell
	initial forever begin
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge aclk);
			c[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge aclk);
		if (txd === 1'h1)
			got.push_back(c);
	end
endmodule // uart_far_end

// File: rtl/hs_uart_flow_fifo_control.v
// Purpose: UART control-word upper half: modem pins, flow control, echo, 32-byte FIFOs, AXI4-Lite slave
// Assumes: One clock aclk, synchronous active-low aresetn, 8N1 framing at a fixed bit period
// Notes: Serial inputs pass a two-stage synchroniser before use
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`include "hs_uart_map.vh"

module hs_uart_flow_fifo_control (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        rxd,
	input  wire        clear_to_send_pin_n,
	output reg         txd,
	output reg         terminal_ready_pin_n,
	output reg         send_request_pin_n
);

	reg  [31:0] uart_control_word;
	reg  [31:0] next_rdata;
	reg  [15:0] ctl_char, tx_cnt, rx_cnt;
	reg  [9:0]  tx_shift;
	reg  [7:0]  tx_mem [0:31];
	reg  [7:0]  rx_mem [0:31];
	reg  [7:0]  rx_shift, rx_char, echo_data;
	reg  [5:0]  tx_count, rx_count, tx_thr, rx_thr;
	reg  [4:0]  tx_wr, tx_rd, rx_wr, rx_rd;
	reg  [3:0]  tx_bit, rx_bit;
	reg  [1:0]  rxd_sync, cts_sync, next_rresp;
	reg         tx_busy, rx_busy, rx_done, echo_pend, xoff_hold;
	wire tx_fifo_enable    = uart_control_word[`TX_FIFO_ENABLE];
	wire rx_fifo_enable    = uart_control_word[`RX_FIFO_ENABLE];
	wire tx_fifo_clear     = uart_control_word[`TX_FIFO_CLEAR];
	wire rx_fifo_clear     = uart_control_word[`RX_FIFO_CLEAR];
	wire hw_flow_enable    = uart_control_word[`HW_FLOW_ENABLE];
	wire sw_flow_enable    = uart_control_word[`SW_FLOW_ENABLE];
	wire echo_enable       = uart_control_word[`ECHO_ENABLE];
	wire flow_pin_select   = uart_control_word[`FLOW_PIN_SELECT];
	wire [1:0] tx_fifo_threshold = uart_control_word[`TX_THR_HI:`TX_THR_LO];
	wire [1:0] rx_fifo_threshold = uart_control_word[`RX_THR_HI:`RX_THR_LO];
	// Capacity is the FIFO depth or a single holding slot
	wire [5:0] tx_cap = tx_fifo_enable ? `FIFO_DEPTH : 6'h01;
	wire [5:0] rx_cap = rx_fifo_enable ? `FIFO_DEPTH : 6'h01;
	// Bus strobes: ready is high for the one handshake cycle
	wire wr_fire = s_axi_awready;
	wire rd_fire = s_axi_arready;
	wire tx_push = wr_fire && (s_axi_awaddr == `OFF_TX_DATA) && s_axi_wstrb[0] && !echo_enable
		&& !tx_fifo_clear && (tx_count < tx_cap);
	wire rx_pop  = rd_fire && (s_axi_araddr == `OFF_RX_DATA) && (rx_count != 6'h00);
	wire rx_push = rx_done && !rx_fifo_clear && (rx_count < rx_cap);
	// Transmit start: echo source replaces the holding buffer, gated by flow control
	wire tx_src  = echo_enable ? echo_pend : (tx_count != 6'h00);
	wire tx_go   = !tx_busy && tx_src && !(hw_flow_enable && cts_sync[1])
		&& !xoff_hold;
	wire tx_pop  = tx_go && !echo_enable;
	wire [7:0] tx_byte = echo_enable ? echo_data : tx_mem[tx_rd];
	// Full single buffer equals not-empty, so one compare serves both modes
	wire ready_to_receive = (rx_count == rx_cap);
	wire [5:0] tx_free    = `FIFO_DEPTH - tx_count;
	wire tx_trigger = tx_fifo_enable ? (tx_free >= tx_thr) : (tx_count == 6'h00);
	wire rx_trigger = rx_fifo_enable ? (rx_count >= rx_thr) : (rx_count != 6'h00);

	// Threshold lookup
	always @* begin
		case (tx_fifo_threshold)
			2'h0:    tx_thr = `TX_THR_0;
			2'h1:    tx_thr = `TX_THR_1;
			2'h2:    tx_thr = `TX_THR_2;
			default: tx_thr = `TX_THR_3;
		endcase
		case (rx_fifo_threshold)
			2'h0:    rx_thr = `RX_THR_0;
			2'h1:    rx_thr = `RX_THR_1;
			2'h2:    rx_thr = `RX_THR_2;
			default: rx_thr = `RX_THR_3;
		endcase
	end

	// Input synchronisers, idle high
	always @(posedge aclk) begin
		if (!aresetn) begin
			rxd_sync <= 2'h3;
			cts_sync <= 2'h3;
		end else begin
			rxd_sync <= {rxd_sync[0], rxd};
			cts_sync <= {cts_sync[0], clear_to_send_pin_n};
		end
	end

	// Control and control-character registers with byte strobes
	always @(posedge aclk) begin
		if (!aresetn) begin
			uart_control_word <= `CONTROL_RESET;
			ctl_char          <= `CTL_CHAR_RESET;
		end else if (wr_fire && s_axi_awaddr == `OFF_CONTROL) begin
			uart_control_word <= ((uart_control_word & ~{{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}) | (s_axi_wdata & {{8{s_axi_wstrb[3]}},
				{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}})) & `CONTROL_WMASK;
		end else if (wr_fire && s_axi_awaddr == `OFF_CTL_CHAR) begin
			if (s_axi_wstrb[0]) ctl_char[7:0]  <= s_axi_wdata[7:0];
			if (s_axi_wstrb[1]) ctl_char[15:8] <= s_axi_wdata[15:8];
		end
	end

	// Write channel: take address and data together, then answer
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == `OFF_CONTROL || s_axi_awaddr == `OFF_TX_DATA ||
					s_axi_awaddr == `OFF_RX_DATA || s_axi_awaddr == `OFF_STATUS ||
					s_axi_awaddr == `OFF_CTL_CHAR) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data selection
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		case (s_axi_araddr)
			`OFF_CONTROL:  next_rdata = uart_control_word;
			`OFF_TX_DATA:  next_rdata = 32'h00000000;
			`OFF_RX_DATA:  next_rdata = {24'h000000, rx_mem[rx_rd]} & {32{rx_count != 6'h00}};
			`OFF_STATUS:   next_rdata = {11'h000, tx_busy, xoff_hold, rx_trigger, tx_trigger,
				rx_count != 6'h00, 2'h0, rx_count, 2'h0, tx_count};
			`OFF_CTL_CHAR: next_rdata = {16'h0000, ctl_char};
			default:       next_rresp = `RESP_SLVERR;
		endcase
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rresp;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Transmit FIFO, held empty while its clear bit stands
	always @(posedge aclk) begin
		if (!aresetn || tx_fifo_clear) begin
			tx_wr    <= 5'h00;
			tx_rd    <= 5'h00;
			tx_count <= 6'h00;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr] <= s_axi_wdata[7:0];
				tx_wr         <= tx_wr + 5'h01;
			end
			if (tx_pop)
				tx_rd <= tx_rd + 5'h01;
			if (tx_push && !tx_pop)
				tx_count <= tx_count + 6'h01;
			else if (tx_pop && !tx_push)
				tx_count <= tx_count - 6'h01;
		end
	end

	// Receive FIFO, held empty while its clear bit stands
	always @(posedge aclk) begin
		if (!aresetn || rx_fifo_clear) begin
			rx_wr    <= 5'h00;
			rx_rd    <= 5'h00;
			rx_count <= 6'h00;
		end else begin
			if (rx_push) begin
				rx_mem[rx_wr] <= rx_char;
				rx_wr         <= rx_wr + 5'h01;
			end
			if (rx_pop)
				rx_rd <= rx_rd + 5'h01;
			if (rx_push && !rx_pop)
				rx_count <= rx_count + 6'h01;
			else if (rx_pop && !rx_push)
				rx_count <= rx_count - 6'h01;
		end
	end

	// Transmit serializer: start, 8 data bits LSB first, stop; unaffected by FIFO clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy  <= 1'b0;
			tx_cnt   <= 16'h0000;
			tx_bit   <= 4'h0;
			tx_shift <= 10'h3ff;
			txd      <= 1'b1;
		end else if (!tx_busy) begin
			if (tx_go) begin
				tx_busy  <= 1'b1;
				tx_cnt   <= 16'h0000;
				tx_bit   <= 4'h0;
				tx_shift <= {1'b1, tx_byte, 1'b0};
				txd      <= 1'b0;
			end
		end else if (tx_cnt == `BIT_CYCLES - 16'h0001) begin
			tx_cnt <= 16'h0000;
			if (tx_bit == 4'h9) begin
				tx_busy <= 1'b0;
				txd     <= 1'b1;
			end else begin
				tx_shift <= {1'b1, tx_shift[9:1]};
				txd      <= tx_shift[1];
				tx_bit   <= tx_bit + 4'h1;
			end
		end else begin
			tx_cnt <= tx_cnt + 16'h0001;
		end
	end

	// Receive deserializer: checks start at mid-bit, drops frames with a bad stop bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_busy  <= 1'b0;
			rx_cnt   <= 16'h0000;
			rx_bit   <= 4'h0;
			rx_shift <= 8'h00;
			rx_done  <= 1'b0;
			rx_char  <= 8'h00;
		end else begin
			rx_done <= 1'b0;
			if (!rx_busy) begin
				if (!rxd_sync[1]) begin
					rx_busy <= 1'b1;
					rx_cnt  <= 16'h0000;
					rx_bit  <= 4'h0;
				end
			end else if (rx_cnt == ((rx_bit == 4'h0) ? `HALF_BIT_CYCLES : `BIT_CYCLES - 16'h0001)) begin
				rx_cnt <= 16'h0000;
				if (rx_bit == 4'h0) begin
					rx_busy <= !rxd_sync[1];
					rx_bit  <= 4'h1;
				end else if (rx_bit == 4'h9) begin
					rx_busy <= 1'b0;
					rx_done <= rxd_sync[1];
					rx_char <= rx_shift;
				end else begin
					rx_shift <= {rxd_sync[1], rx_shift[7:1]};
					rx_bit   <= rx_bit + 4'h1;
				end
			end else begin
				rx_cnt <= rx_cnt + 16'h0001;
			end
		end
	end

	// Echo capture and in-band pause; a new arrival wins over the take
	always @(posedge aclk) begin
		if (!aresetn) begin
			echo_pend <= 1'b0;
			echo_data <= 8'h00;
			xoff_hold <= 1'b0;
		end else begin
			if (rx_done && echo_enable) begin
				echo_pend <= 1'b1;
				echo_data <= rx_char;
			end else if (tx_go && echo_enable) begin
				echo_pend <= 1'b0;
			end
			if (!sw_flow_enable)
				xoff_hold <= 1'b0;
			else if (rx_done && rx_char == ctl_char[7:0])
				xoff_hold <= 1'b1;
			else if (rx_done && rx_char == ctl_char[15:8])
				xoff_hold <= 1'b0;
		end
	end

	// Modem pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			terminal_ready_pin_n <= 1'b1;
			send_request_pin_n   <= 1'b1;
		end else begin
			terminal_ready_pin_n <= !uart_control_word[`DTR_BIT];
			if (hw_flow_enable || flow_pin_select)
				send_request_pin_n <= ready_to_receive;
			else
				send_request_pin_n <= !uart_control_word[`RTS_BIT];
		end
	end

endmodule // hs_uart_flow_fifo_control

// File: shared/hs_uart_map.vh
// Purpose: Register offsets, field positions, reset values and timing for the UART flow/FIFO block
// Assumes: Included by bare name from the design file
// Notes: Definitions only
`ifndef HS_UART_MAP_VH
`define HS_UART_MAP_VH

// Byte offsets on the register bus
`define OFF_CONTROL      8'h00
`define OFF_TX_DATA      8'h04
`define OFF_RX_DATA      8'h08
`define OFF_STATUS       8'h0c
`define OFF_CTL_CHAR     8'h10

// Control word fields
`define TX_FIFO_ENABLE   16
`define RX_FIFO_ENABLE   17
`define TX_FIFO_CLEAR    18
`define RX_FIFO_CLEAR    19
`define TX_THR_LO        20
`define TX_THR_HI        21
`define RX_THR_LO        22
`define RX_THR_HI        23
`define DTR_BIT          24
`define RTS_BIT          25
`define HW_FLOW_ENABLE   28
`define SW_FLOW_ENABLE   29
`define ECHO_ENABLE      30
`define FLOW_PIN_SELECT  31

// Reserved bits 27:26 are never stored
`define CONTROL_WMASK    32'hf3ffffff
`define CONTROL_RESET    32'h00000000
`define CTL_CHAR_RESET   16'h1113

// FIFO geometry
`define FIFO_DEPTH       6'h20

// Transmit free-space thresholds for codes 00..11
`define TX_THR_0         6'h1e
`define TX_THR_1         6'h18
`define TX_THR_2         6'h10
`define TX_THR_3         6'h08

// Receive fill thresholds for codes 00..11
`define RX_THR_0         6'h01
`define RX_THR_1         6'h08
`define RX_THR_2         6'h12
`define RX_THR_3         6'h1c

// Serial bit period in clock cycles and half of it
`define BIT_CYCLES       16'h0010
`define HALF_BIT_CYCLES  16'h0008

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif
